//--- timer_quirks_pkg.sv
// Constants, modes and register layout shared by the timer pair.
package timer_quirks_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TA_PERIOD = 8'h08;
  localparam logic [7:0] OFS_TA_DUTY = 8'h0C;
  localparam logic [7:0] OFS_TB_COUNT = 8'h10;
  localparam logic [7:0] OFS_TB_RELOAD = 8'h14;
  localparam int ADR_W = 8;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int POS_TA_START = 0;
  localparam int POS_TB_START = 1;
  localparam int POS_TA_MODE = 2;
  localparam int POS_TB_MODE = 4;
  localparam int POS_TB_MSEL = 6;
  localparam int POS_TA_IRQ = 0;
  localparam int POS_TB_IRQ = 1;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_TA_PERIOD = 16'hFFFF;
  localparam logic [15:0] RST_TA_DUTY = 16'h0000;
  localparam logic [15:0] RST_TB_COUNT = 16'h0000;
  // ****************************************
  // Modes and carriers
  // ****************************************
  typedef enum logic [1:0] {
    TA_TIMER,
    TA_EVENT,
    TA_ONESHOT,
    TA_PWM
  } ta_mode_e;
  typedef enum logic [1:0] {
    TB_TIMER,
    TB_EVENT,
    TB_MEASURE,
    TB_RSVD
  } tb_mode_e;
  typedef struct packed {
    logic tb_msel;
    tb_mode_e tb_mode;
    ta_mode_e ta_mode;
    logic tb_start;
    logic ta_start;
  } ctrl_s;
  localparam ctrl_s RST_CTRL = '{1'b0, TB_TIMER, TA_TIMER, 1'b0, 1'b0};
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
  } wb_req_s;
endpackage

//--- timer_quirks.sv
// Timer A (timer, event, PWM) and timer B (timer, event, measurement) behind Wishbone.
// Summary of operation
// - Entering PWM from timer/event sets A flag.
// - Clearing start during PWM stops count.
// - Stop with pin high: pin low, flag.
// - Stop with pin low: stays low, no flag.
// - Running B count reads live value; in measure mode it reads the last capture.
// - B read at reload cycle returns all ones.
// - Halted B write reads back before start.
// - Changing measure select while running in measure mode sets flag.
// - First measure edge: reload junk, no flag.
`timescale 1ns/1ps
module timer_quirks
  import timer_quirks_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ta_event_i,
  input wire logic tb_in_i,
  input wire logic ta_irq_ack_i,
  input wire logic tb_irq_ack_i,
  output logic pwm_output_pin_o,
  output logic ta_irq_o,
  output logic tb_irq_o
);
  // ****************************************
  // Elaboration check
  // ****************************************
  if (CNT_W != 16) begin : g_bad_width
    $error("timer_quirks: CNT_W must be 16");
  end

  localparam logic [CNT_W-1:0] ALL_ONES = '1;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  wb_req_s req;
  assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i};

  ctrl_s ctrl, next_ctrl;
  logic ta_irq, next_ta_irq, tb_irq, next_tb_irq;
  logic [CNT_W-1:0] ta_period, next_ta_period, ta_duty, next_ta_duty;
  logic [CNT_W-1:0] ta_cnt, next_ta_cnt;
  logic pin, next_pin;
  logic [CNT_W-1:0] tb_cnt, next_tb_cnt, tb_reload, next_tb_reload;
  logic tb_first, next_tb_first;
  logic ta_ev_d, tb_in_d;
  logic [31:0] dat_o, next_dat_o;
  logic ack, next_ack;

  // ****************************************
  // Bus, control and counters
  // ****************************************
  always_comb begin
    logic acc, wr;
    logic [31:0] wdat;
    logic ta_tick, tb_tick, tb_edge, ta_set, tb_set, tb_at_reload;
    ctrl_s wctrl;
    acc = req.cyc && req.stb && !ack;
    wr = acc && req.we;
    wdat = 32'h0000_0000;
    wctrl = ctrl;
    ta_set = 1'b0;
    tb_set = 1'b0;
    next_ctrl = ctrl;
    next_ta_period = ta_period;
    next_ta_duty = ta_duty;
    next_ta_cnt = ta_cnt;
    next_pin = pin;
    next_tb_cnt = tb_cnt;
    next_tb_reload = tb_reload;
    next_tb_first = tb_first;
    next_ack = acc;
    next_dat_o = dat_o;
    ta_tick = (ctrl.ta_mode == TA_EVENT) ? (ta_event_i && !ta_ev_d) : 1'b1;
    tb_tick = (ctrl.tb_mode == TB_EVENT) ? (tb_in_i && !tb_in_d) : 1'b1;
    tb_edge = ctrl.tb_msel ? (tb_in_i != tb_in_d) : (tb_in_i && !tb_in_d);
    tb_at_reload = ctrl.tb_start && tb_tick && (tb_cnt == '0);

    // Timer A counting.
    if (ctrl.ta_start) begin
      if (ctrl.ta_mode == TA_PWM) begin
        next_ta_cnt = (ta_cnt >= ta_period) ? '0 : ta_cnt + 1'b1;
        next_pin = (next_ta_cnt < ta_duty);
        if (pin && !next_pin) begin
          ta_set = 1'b1;
        end
      end else if (ta_tick) begin
        if (ta_cnt == '0) begin
          next_ta_cnt = ta_period;
          ta_set = 1'b1;
        end else begin
          next_ta_cnt = ta_cnt - 1'b1;
        end
      end
    end

    // Timer B counting.
    if (ctrl.tb_start) begin
      if (ctrl.tb_mode == TB_MEASURE) begin
        next_tb_cnt = tb_cnt + 1'b1;
        if (tb_edge) begin
          next_tb_cnt = '0;
          next_tb_reload = tb_cnt;
          next_tb_first = 1'b0;
          if (!tb_first) begin
            tb_set = 1'b1;
          end
        end
      end else if (tb_at_reload) begin
        next_tb_cnt = tb_reload;
        tb_set = 1'b1;
      end else if (tb_tick) begin
        next_tb_cnt = tb_cnt - 1'b1;
      end
    end

    // Register writes.
    if (wr) begin
      case (req.adr)
        OFS_CTRL: begin
          wdat = merge({25'h0, ctrl}, req.dat, req.sel);
          wctrl = ctrl_s'(wdat[6:0]);
          next_ctrl = wctrl;
          if (wctrl.ta_mode == TA_PWM &&
              (ctrl.ta_mode == TA_TIMER || ctrl.ta_mode == TA_EVENT)) begin
            ta_set = 1'b1;
          end
          if (ctrl.ta_mode == TA_PWM && ctrl.ta_start && !wctrl.ta_start) begin
            next_ta_cnt = ta_cnt;
            next_pin = 1'b0;
            ta_set = pin;
          end
          if (wctrl.ta_mode != TA_PWM) begin
            next_pin = 1'b0;
          end
          if (ctrl.tb_mode == TB_MEASURE && ctrl.tb_start &&
              wctrl.tb_msel != ctrl.tb_msel) begin
            tb_set = 1'b1;
          end
          if (!ctrl.tb_start && wctrl.tb_start) begin
            next_tb_first = 1'b1;
            if (wctrl.tb_mode == TB_MEASURE) begin
              next_tb_cnt = '0;
            end
          end
        end
        OFS_TA_PERIOD: begin
          wdat = merge({16'h0, ta_period}, req.dat, req.sel);
          next_ta_period = wdat[CNT_W-1:0];
          if (!ctrl.ta_start) begin
            next_ta_cnt = wdat[CNT_W-1:0];
          end
        end
        OFS_TA_DUTY: begin
          wdat = merge({16'h0, ta_duty}, req.dat, req.sel);
          next_ta_duty = wdat[CNT_W-1:0];
        end
        OFS_TB_COUNT: begin
          wdat = merge({16'h0, tb_reload}, req.dat, req.sel);
          next_tb_reload = wdat[CNT_W-1:0];
          if (!ctrl.tb_start) begin
            next_tb_cnt = wdat[CNT_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    next_ta_irq = ta_irq && !ta_irq_ack_i;
    next_tb_irq = tb_irq && !tb_irq_ack_i;
    if (wr && req.adr == OFS_STATUS && req.sel[0]) begin
      if (!req.dat[POS_TA_IRQ]) begin
        next_ta_irq = 1'b0;
      end
      if (!req.dat[POS_TB_IRQ]) begin
        next_tb_irq = 1'b0;
      end
    end
    if (ta_set) begin
      next_ta_irq = 1'b1;
    end
    if (tb_set) begin
      next_tb_irq = 1'b1;
    end

    // Register reads.
    if (acc && !req.we) begin
      case (req.adr)
        OFS_CTRL: next_dat_o = {25'h0, ctrl};
        OFS_STATUS: next_dat_o = {30'h0, tb_irq, ta_irq};
        OFS_TA_PERIOD: next_dat_o = {16'h0, ta_period};
        OFS_TA_DUTY: next_dat_o = {16'h0, ta_duty};
        OFS_TB_COUNT: begin
          if (ctrl.tb_mode == TB_MEASURE) begin
            next_dat_o = {16'h0, tb_reload};
          end else if (tb_at_reload) begin
            next_dat_o = {16'h0, ALL_ONES};
          end else begin
            next_dat_o = {16'h0, tb_cnt};
          end
        end
        OFS_TB_RELOAD: next_dat_o = {16'h0, tb_reload};
        default: next_dat_o = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= RST_CTRL;
      ta_irq <= 1'b0;
      tb_irq <= 1'b0;
      ta_period <= RST_TA_PERIOD;
      ta_duty <= RST_TA_DUTY;
      ta_cnt <= RST_TA_PERIOD;
      pin <= 1'b0;
      tb_cnt <= RST_TB_COUNT;
      tb_reload <= RST_TB_COUNT;
      tb_first <= 1'b0;
      ta_ev_d <= 1'b0;
      tb_in_d <= 1'b0;
      dat_o <= 32'h0000_0000;
      ack <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      ta_irq <= next_ta_irq;
      tb_irq <= next_tb_irq;
      ta_period <= next_ta_period;
      ta_duty <= next_ta_duty;
      ta_cnt <= next_ta_cnt;
      pin <= next_pin;
      tb_cnt <= next_tb_cnt;
      tb_reload <= next_tb_reload;
      tb_first <= next_tb_first;
      ta_ev_d <= ta_event_i;
      tb_in_d <= tb_in_i;
      dat_o <= next_dat_o;
      ack <= next_ack;
    end
  end

  // Outputs are the flip-flops themselves, so no logic sits after them.
  assign wb_dat_o = dat_o;
  assign wb_ack_o = ack;
  assign pwm_output_pin_o = pin;
  assign ta_irq_o = ta_irq;
  assign tb_irq_o = tb_irq;
endmodule // timer_quirks

//--- timer_quirks_chk.sv
// Checker of the timer pair, watching only the top module ports.
`timescale 1ns/1ps
module timer_quirks_chk
  import timer_quirks_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic ta_event_i,
  input wire logic tb_in_i,
  input wire logic ta_irq_ack_i,
  input wire logic tb_irq_ack_i,
  input wire logic pwm_output_pin_o,
  input wire logic ta_irq_o,
  input wire logic tb_irq_o
);
  // ****
  // Shadow of the control word.
  // ****
  ctrl_s shadow;
  ctrl_s next_shadow;
  logic wr;
  logic stop;
  logic clr_a;
  logic clr_b;
  assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign stop = wr && wb_adr_i == OFS_CTRL && shadow.ta_mode == TA_PWM && shadow.ta_start
      && wb_dat_i[3:2] == 2'b11 && !wb_dat_i[0];
  assign clr_a = wr && wb_adr_i == OFS_STATUS && !wb_dat_i[0];
  assign clr_b = wr && wb_adr_i == OFS_STATUS && !wb_dat_i[1];
  always_comb begin
    next_shadow = shadow;
    if (wr && wb_adr_i == OFS_CTRL) begin
      next_shadow = ctrl_s'(wb_dat_i[6:0]);
    end
  end
  always_ff @(posedge clk_i) begin
    shadow <= rst_i ? RST_CTRL : next_shadow;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence pin_drop_s;
    ##1 (!pwm_output_pin_o && ta_irq_o);
  endsequence
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_answer_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  pwm_entry_a:
    assert property (wr && wb_adr_i == OFS_CTRL && wb_dat_i[3:2] == 2'b11
      && shadow.ta_mode inside {TA_TIMER, TA_EVENT} |=> ta_irq_o) else $error("no flag");
  pwm_halt_a:
    assert property (stop |=> !pwm_output_pin_o [*2]) else $error("pin after stop");
  stop_high_a:
    assert property (stop && pwm_output_pin_o |-> pin_drop_s) else $error("stop high");
  stop_low_a:
    assert property (stop && !pwm_output_pin_o && !ta_irq_o |=> !pwm_output_pin_o
      && !ta_irq_o) else $error("stop low");
  msel_change_a:
    assert property (wr && wb_adr_i == OFS_CTRL && shadow.tb_mode == TB_MEASURE
      && shadow.tb_start && wb_dat_i[5:4] == 2'b10 && wb_dat_i[1]
      && wb_dat_i[6] != shadow.tb_msel |=> tb_irq_o) else $error("no select flag");
  ta_hold_a:
    assert property (ta_irq_o && !ta_irq_ack_i && !clr_a |=> ta_irq_o) else $error("a lost");
  tb_hold_a:
    assert property (tb_irq_o && !tb_irq_ack_i && !clr_b |=> tb_irq_o) else $error("b lost");
endmodule // timer_quirks_chk
bind timer_quirks timer_quirks_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ta_event_i(ta_event_i),
  .tb_in_i(tb_in_i), .ta_irq_ack_i(ta_irq_ack_i), .tb_irq_ack_i(tb_irq_ack_i),
  .pwm_output_pin_o(pwm_output_pin_o), .ta_irq_o(ta_irq_o), .tb_irq_o(tb_irq_o));

//--- timer_quirks_test.sv
// Self-checking bench of the timer pair.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module timer_quirks_test
  import timer_quirks_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ta_event_i = 1'b0;
  logic tb_in_i = 1'b0;
  logic ta_irq_ack_i = 1'b0;
  logic tb_irq_ack_i = 1'b0;
  logic man_en = 1'b0;
  logic man_in = 1'b0;
  logic seen;
  logic [15:0] d;
  logic [31:0] q;
  logic [31:0] lfsr = 32'h0000_81df;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, pwm_output_pin_o, ta_irq_o, tb_irq_o;
  wb_req_s req = '0;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #10 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ctrl(ta_mode_e am, logic as, tb_mode_e bm, logic bs, logic ms);
    return {25'h0, ms, bm, am, bs, as};
  endfunction
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // The event and B input pins see random edges; a scenario can take over only the B input.
  always @(posedge clk_i) begin
    lfsr <= lfsr_next(lfsr);
    ta_event_i <= lfsr[3];
    tb_in_i <= man_en ? man_in : lfsr[5];
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end
  timer_quirks u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ta_event_i(ta_event_i), .tb_in_i(tb_in_i),
    .ta_irq_ack_i(ta_irq_ack_i), .tb_irq_ack_i(tb_irq_ack_i),
    .pwm_output_pin_o(pwm_output_pin_o), .ta_irq_o(ta_irq_o), .tb_irq_o(tb_irq_o));
  // Only the cycle ceiling ends a wait for ack, so a hang is always counted.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat);
    req <= '{1'b1, 1'b1, we, 4'hF, a, dat};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    req <= '0;
    @(posedge clk_i);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OFS_TA_PERIOD, 32'h0);
    `CHK(q, 32'h0000_FFFF);
    wb(1'b0, 8'h3C, 32'h0);
    `CHK(q, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, OFS_CTRL, ctrl(i ? TA_EVENT : TA_TIMER, 1'b0, TB_TIMER, 1'b0, 1'b0));
      wb(1'b1, OFS_STATUS, 32'h0);
      wb(1'b1, OFS_CTRL, ctrl(TA_PWM, 1'b0, TB_TIMER, 1'b0, 1'b0));
      `CHK(ta_irq_o, 1'b1);
      if (i == 0) begin
        wb(1'b1, OFS_STATUS, 32'h0);
      end else begin
        ta_irq_ack_i <= 1'b1;
        @(posedge clk_i);
        ta_irq_ack_i <= 1'b0;
        @(posedge clk_i);
      end
      `CHK(ta_irq_o, 1'b0);
      wb(1'b1, OFS_TA_PERIOD, {28'h0, lfsr[3:0] | 4'h2});
      wb(1'b1, OFS_TA_DUTY, i ? 32'h0 : 32'h0000_FFFF);
      wb(1'b1, OFS_CTRL, ctrl(TA_PWM, 1'b1, TB_TIMER, 1'b0, 1'b0));
      repeat (4) @(posedge clk_i);
      `CHK(pwm_output_pin_o, i == 0);
      wb(1'b1, OFS_CTRL, ctrl(TA_PWM, 1'b0, TB_TIMER, 1'b0, 1'b0));
      `CHK(pwm_output_pin_o, 1'b0);
      `CHK(ta_irq_o, i == 0);
    end
    repeat (4) begin
      d = lfsr[15:0];
      wb(1'b1, OFS_TB_COUNT, {16'h0, d});
      wb(1'b0, OFS_TB_COUNT, 32'h0);
      `CHK(q[15:0], d);
    end
    wb(1'b1, OFS_TB_COUNT, 32'h0000_0001);
    wb(1'b1, OFS_CTRL, ctrl(TA_PWM, 1'b0, TB_TIMER, 1'b1, 1'b0));
    seen = 1'b0;
    repeat (8) begin
      wb(1'b0, OFS_TB_COUNT, 32'h0);
      if (q[15:0] === 16'hFFFF) seen = 1'b1;
      else `CHK(q[15:0], 16'h0001);
    end
    `CHK(seen, 1'b1);
    man_en <= 1'b1;
    wb(1'b1, OFS_CTRL, ctrl(TA_PWM, 1'b0, TB_EVENT, 1'b0, 1'b0));
    wb(1'b1, OFS_TB_COUNT, 32'h0000_0005);
    wb(1'b1, OFS_CTRL, ctrl(TA_PWM, 1'b0, TB_EVENT, 1'b1, 1'b0));
    wb(1'b0, OFS_TB_COUNT, 32'h0);
    `CHK(q[15:0], 16'h0005);
    man_in <= 1'b1;
    repeat (4) @(posedge clk_i);
    man_in <= 1'b0;
    wb(1'b0, OFS_TB_COUNT, 32'h0);
    `CHK(q[15:0], 16'h0004);
    wb(1'b1, OFS_CTRL, ctrl(TA_PWM, 1'b0, TB_MEASURE, 1'b0, 1'b0));
    wb(1'b1, OFS_STATUS, 32'h0);
    wb(1'b1, OFS_CTRL, ctrl(TA_PWM, 1'b0, TB_MEASURE, 1'b1, 1'b0));
    for (int k = 0; k < 2; k++) begin
      man_in <= 1'b1;
      repeat (4) @(posedge clk_i);
      man_in <= 1'b0;
      repeat (4) @(posedge clk_i);
      `CHK(tb_irq_o, k == 1);
    end
    wb(1'b1, OFS_STATUS, 32'h0);
    `CHK(tb_irq_o, 1'b0);
    wb(1'b1, OFS_CTRL, ctrl(TA_PWM, 1'b0, TB_MEASURE, 1'b1, 1'b1));
    `CHK(tb_irq_o, 1'b1);
    tb_irq_ack_i <= 1'b1;
    @(posedge clk_i);
    tb_irq_ack_i <= 1'b0;
    @(posedge clk_i);
    `CHK(tb_irq_o, 1'b0);
    end_sim();
  end
endmodule // timer_quirks_test
